// ---- verilog/sirq_device.sv ----
`timescale 1ns/1ps
// Behaviour
// - Quiet idle: drive low one clock, release
// - Never start while the line is Active
// - Track Idle and Active line state
// - Host stretches Start low four to eight clocks
// - Host drives high one clock then releases
// - Interrupt change opens Start unless deliverable
// - Continuous mode: device never starts
// - Host may restart after every Stop
// - Mode changes only at Stop Frame
// - Reset leaves the bus in Continuous
// - Measure every Stop pulse low width
// - Two clocks Quiet, three clocks Continuous
// - Tolerate any Idle clocks in Stop
// - Accept Start right after turnaround or later
// - Frames of Sample, Recovery, Turn-around
// - Low only if level low; high after low
// - Sample N at 3N-2; frames 2-16 carry
// - Reset: line released, Continuous mode
`include "sirq_map.svh"
module sirq_device
   import sirq_pkg::*;
(
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   input  wire logic                      clk_en,
   // Interrupt lines 1 to 15, bit 0 is line 1
   input  wire logic [`SIRQ_NUM_IRQ-1:0]  irq_in,
   // Status
   output logic                           mode_quiet,
   output logic                           bus_active,
   // Serial line
   sirq_if.dev                            sio
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [`SIRQ_NUM_IRQ-1:0] irq_s1_reg, irq_s1_next;
   logic [`SIRQ_NUM_IRQ-1:0] irq_s2_reg, irq_s2_next;
   logic [`SIRQ_NUM_IRQ-1:0] irq_lvl_reg, irq_lvl_next;
   logic                     line_s1_reg, line_s1_next;
   logic                     line_s2_reg, line_s2_next;
   logic                     line_d_reg, line_d_next;

   // Two flops on every outside input, then a registered copy
   always_comb begin
      irq_s1_next  = irq_in;
      irq_s2_next  = irq_s1_reg;
      irq_lvl_next = irq_s2_reg;
      line_s1_next = sio.line;
      line_s2_next = line_s1_reg;
      line_d_next  = line_s2_reg;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_s1_reg  <= '1;
         irq_s2_reg  <= '1;
         irq_lvl_reg <= '1;
         line_s1_reg <= 1'b1;
         line_s2_reg <= 1'b1;
         line_d_reg  <= 1'b1;
      end else if (clk_en) begin
         irq_s1_reg  <= irq_s1_next;
         irq_s2_reg  <= irq_s2_next;
         irq_lvl_reg <= irq_lvl_next;
         line_s1_reg <= line_s1_next;
         line_s2_reg <= line_s2_next;
         line_d_reg  <= line_d_next;
      end
   end

   // ------------------------------------------------------------
   // Cycle tracking and line drive
   // ------------------------------------------------------------
   dev_state_t               state_reg, state_next;
   bus_mode_t                mode_reg, mode_next;
   logic [`SIRQ_CNT_W-1:0]   cnt_reg, cnt_next;
   logic [3:0]               low_reg, low_next;
   logic [`SIRQ_NUM_IRQ-1:0] sent_reg, sent_next;
   logic                     pend_reg, pend_next;
   logic                     drv_reg, drv_next;
   logic                     oe_reg, oe_next;
   logic                     lowed_reg, lowed_next;
   logic                     rise, fall;
   logic [1:0]               phase;
   logic [4:0]               frame;
   logic [`SIRQ_NUM_IRQ-1:0] irq_chg;
   logic                     sample_bit;

   assign rise  = line_s2_reg & ~line_d_reg;
   assign fall  = ~line_s2_reg & line_d_reg;
   assign phase = 2'((cnt_reg + 6'h01) % `SIRQ_FRAME_CLKS);
   // Frame number N, so that Sample of frame N falls at count 3N-2
   assign frame = 5'((cnt_reg + `SIRQ_DEV_FRAME_OFS) / `SIRQ_FRAME_CLKS);
   assign irq_chg = irq_lvl_reg ^ sent_reg;

   // Level carried by the frame now at hand
   always_comb begin
      sample_bit = 1'b1;
      if (frame >= `SIRQ_FIRST_IRQ_FRAME && frame <= 5'h10) begin
         sample_bit = irq_lvl_reg[4'(frame - `SIRQ_FIRST_IRQ_FRAME)];
      end
   end

   // Next state, counters and drive
   always_comb begin
      state_next = state_reg;
      mode_next  = mode_reg;
      cnt_next   = cnt_reg;
      low_next   = low_reg;
      sent_next  = sent_reg;
      pend_next  = |irq_chg;
      drv_next   = 1'b1;
      oe_next    = 1'b0;
      lowed_next = lowed_reg;
      case (state_reg)
         D_IDLE: begin
            if (fall) begin
               state_next = D_STARTLO;
               low_next   = 4'h1;
            end else if (mode_reg == MODE_QUIET && pend_reg) begin
               state_next = D_START;
               drv_next   = 1'b0;
               oe_next    = 1'b1;
            end
         end
         D_START: begin
            state_next = D_STARTLO;
            low_next   = '0;
         end
         // Own one-clock request is too short to count as the Start
         D_STARTLO: begin
            cnt_next = '0;
            if (!line_s2_reg) begin
               if (low_reg != 4'hF) begin
                  low_next = 4'(low_reg + 4'h1);
               end
            end else if (rise) begin
               low_next = '0;
               if (low_reg >= `SIRQ_START_MIN_LOW) begin
                  state_next = D_FRAMES;
                  sent_next  = irq_lvl_reg;
               end
            end
         end
         D_FRAMES: begin
            cnt_next = 6'(cnt_reg + 6'h01);
            if (phase == 2'h2 && cnt_reg <= `SIRQ_LAST_SAMPLE) begin
               if (!sample_bit) begin
                  drv_next   = 1'b0;
                  oe_next    = 1'b1;
               end
               lowed_next = ~sample_bit;
               if (frame >= `SIRQ_FIRST_IRQ_FRAME && frame <= 5'h10) begin
                  sent_next[4'(frame - `SIRQ_FIRST_IRQ_FRAME)] = sample_bit;
               end
            end else if (phase == 2'h0 && lowed_reg) begin
               drv_next   = 1'b1;
               oe_next    = 1'b1;
               lowed_next = 1'b0;
            end
            // Own last Sample drive is seen late, so wait past it
            if (fall && cnt_reg > `SIRQ_STOP_WATCH) begin
               state_next = D_STOP;
               low_next   = 4'h1;
            end
         end
         D_STOP: begin
            if (!line_s2_reg) begin
               low_next = 4'(low_reg + 4'h1);
            end else begin
               state_next = D_IDLE;
               if (low_reg == `SIRQ_STOP_QUIET) begin
                  mode_next = MODE_QUIET;
               end else if (low_reg >= `SIRQ_STOP_CONT) begin
                  mode_next = MODE_CONT;
               end
            end
         end
         default: state_next = D_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= D_IDLE;
         mode_reg  <= MODE_CONT;
         cnt_reg   <= '0;
         low_reg   <= '0;
         sent_reg  <= '1;
         pend_reg  <= 1'b0;
         drv_reg   <= 1'b1;
         oe_reg    <= 1'b0;
         lowed_reg <= 1'b0;
         mode_quiet <= 1'b0;
         bus_active <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         cnt_reg   <= cnt_next;
         low_reg   <= low_next;
         sent_reg  <= sent_next;
         pend_reg  <= pend_next;
         drv_reg   <= drv_next;
         oe_reg    <= oe_next;
         lowed_reg <= lowed_next;
         mode_quiet <= (mode_next == MODE_QUIET);
         bus_active <= (state_next != D_IDLE);
      end
   end

   assign sio.dev_out = drv_reg;
   assign sio.dev_oe  = oe_reg;

endmodule

// ---- verilog/sirq_map.svh ----
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH

// Frame counts in clocks
`define SIRQ_FRAME_CLKS      6'h03
`define SIRQ_LAST_SAMPLE     6'h2F
`define SIRQ_FIRST_IRQ_FRAME 5'h02
`define SIRQ_CNT_W           6
`define SIRQ_NUM_IRQ         15
`define SIRQ_STOP_QUIET      4'h2
`define SIRQ_STOP_CONT       4'h3
`define SIRQ_START_MIN_EXTRA 3'h3
`define SIRQ_START_MAX_EXTRA 3'h7
`define SIRQ_DEF_FRAMES      5'h11
// Device frame numbering offset from its own count
`define SIRQ_DEV_FRAME_OFS   6'h04
// Count past which a seen fall is the Stop pulse
`define SIRQ_STOP_WATCH      6'h31
// Shortest seen low that counts as a Start pulse
`define SIRQ_START_MIN_LOW   4'h2

`endif

// ---- verilog/sirq_pkg.sv ----
package sirq_pkg;

   // Bus mode, chosen by the Stop pulse width
   typedef enum logic [1:0] {
      MODE_CONT  = 2'h1,
      MODE_QUIET = 2'h2
   } bus_mode_t;

   // Device end states
   typedef enum logic [4:0] {
      D_IDLE    = 5'h01,
      D_START   = 5'h02,
      D_STARTLO = 5'h04,
      D_FRAMES  = 5'h08,
      D_STOP    = 5'h10
   } dev_state_t;

   // Host end states
   typedef enum logic [5:0] {
      H_IDLE    = 6'h01,
      H_START   = 6'h02,
      H_HIGH    = 6'h04,
      H_FRAMES  = 6'h08,
      H_STOP    = 6'h10,
      H_STOPHI  = 6'h20
   } host_state_t;

endpackage

// ---- verilog/sirq_if.sv ----
`timescale 1ns/1ps
// One-wire serial interrupt line shared by both ends
interface sirq_if;
   logic dev_out;
   logic dev_oe;
   logic host_out;
   logic host_oe;
   wire  line;

   // Pulled-up open wire resolved from the enables
   assign line = dev_oe ? dev_out : (host_oe ? host_out : 1'b1);

   modport dev  (output dev_out, output dev_oe, input line);
   modport host (output host_out, output host_oe, input line);
endinterface

// ---- verilog/sirq_host.sv ----
`timescale 1ns/1ps
`include "sirq_map.svh"
module sirq_host
   import sirq_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Control
   input  wire logic        start_req,
   input  wire logic        want_quiet,
   input  wire logic        run_cont,
   input  wire logic [2:0]  start_extra,
   // Result
   output logic [15:0]      irq_lvl,
   output logic             cycle_done,
   // Serial line
   sirq_if.host             sio
);

   // ------------------------------------------------------------
   // Host cycle engine
   // ------------------------------------------------------------
   host_state_t      state_reg, state_next;
   logic [5:0]       cnt_reg, cnt_next;
   logic [2:0]       ext_reg, ext_next;
   logic             quiet_reg, quiet_next;
   logic             drv_reg, drv_next;
   logic             oe_reg, oe_next;
   logic [15:0]      lvl_reg, lvl_next;
   logic             done_reg, done_next;
   logic             l1_reg, l2_reg, ld_reg;
   logic [1:0]       phase;
   logic [4:0]       frame;

   assign phase = 2'((cnt_reg + 6'h01) % `SIRQ_FRAME_CLKS);
   assign frame = 5'((cnt_reg + 6'h01) / `SIRQ_FRAME_CLKS);

   // Line synchroniser
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         l1_reg <= 1'b1;
         l2_reg <= 1'b1;
         ld_reg <= 1'b1;
      end else if (clk_en) begin
         l1_reg <= sio.line;
         l2_reg <= l1_reg;
         ld_reg <= l2_reg;
      end
   end

   // Next state
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      ext_next   = ext_reg;
      quiet_next = quiet_reg;
      drv_next   = 1'b1;
      oe_next    = 1'b0;
      lvl_next   = lvl_reg;
      done_next  = 1'b0;
      case (state_reg)
         H_IDLE: begin
            cnt_next = '0;
            ext_next = (start_extra < `SIRQ_START_MIN_EXTRA) ? `SIRQ_START_MIN_EXTRA
                                                            : start_extra;
            if (start_req || run_cont || (quiet_reg && ~l2_reg && ld_reg)) begin
               state_next = H_START;
               drv_next   = 1'b0;
               oe_next    = 1'b1;
            end
         end
         H_START: begin
            drv_next = 1'b0;
            oe_next  = 1'b1;
            cnt_next = 6'(cnt_reg + 6'h01);
            if (cnt_reg[2:0] >= ext_reg) begin
               state_next = H_HIGH;
               drv_next   = 1'b1;
               cnt_next   = '0;
            end
         end
         H_HIGH: begin
            state_next = H_FRAMES;
         end
         H_FRAMES: begin
            cnt_next = 6'(cnt_reg + 6'h01);
            // Line seen two clocks late: frame N lands in host frame N+1
            if (phase == 2'h1 && frame >= `SIRQ_FIRST_IRQ_FRAME
                && frame <= `SIRQ_DEF_FRAMES) begin
               lvl_next[4'(frame - `SIRQ_FIRST_IRQ_FRAME)] = l2_reg;
            end
            if (frame == `SIRQ_DEF_FRAMES && phase == 2'h1) begin
               state_next = H_STOP;
               quiet_next = want_quiet;
               cnt_next   = '0;
            end
         end
         H_STOP: begin
            drv_next = 1'b0;
            oe_next  = 1'b1;
            cnt_next = 6'(cnt_reg + 6'h01);
            if (cnt_reg[3:0] == (quiet_reg ? `SIRQ_STOP_QUIET : `SIRQ_STOP_CONT)) begin
               state_next = H_STOPHI;
               drv_next   = 1'b1;
            end
         end
         H_STOPHI: begin
            state_next = H_IDLE;
            done_next  = 1'b1;
         end
         default: state_next = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= H_IDLE;
         cnt_reg   <= '0;
         ext_reg   <= `SIRQ_START_MIN_EXTRA;
         quiet_reg <= 1'b0;
         drv_reg   <= 1'b1;
         oe_reg    <= 1'b0;
         lvl_reg   <= '1;
         done_reg  <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         ext_reg   <= ext_next;
         quiet_reg <= quiet_next;
         drv_reg   <= drv_next;
         oe_reg    <= oe_next;
         lvl_reg   <= lvl_next;
         done_reg  <= done_next;
      end
   end

   assign sio.host_out = drv_reg;
   assign sio.host_oe  = oe_reg;
   assign irq_lvl      = lvl_reg;
   assign cycle_done   = done_reg;

endmodule

// ---- verification/sirq_asserts.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Line checker
// ----------------------------------------
module sirq_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Line drives and resolved level
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic host_out,
   input wire logic host_oe,
   input wire logic line
);
   logic [3:0] lo_reg;
   logic [3:0] lo_next;
   logic       seen_reg;
   logic       seen_next;
   logic       dev_lo;
   logic       dev_hi;
   logic       host_lo;
   logic       host_hi;

   // Drive decode
   assign dev_lo  = dev_oe && !dev_out;
   assign dev_hi  = dev_oe && dev_out;
   assign host_lo = host_oe && !host_out;
   assign host_hi = host_oe && host_out;

   // Low run length, host-first flag
   always_comb begin
      lo_next = line ? 4'h0 : ((lo_reg == 4'hF) ? lo_reg : lo_reg + 4'h1);
      seen_next = seen_reg | host_oe;
   end

   // Helper registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_reg <= 4'h0;
         seen_reg <= 1'b0;
      end else begin
         lo_reg <= lo_next;
         seen_reg <= seen_next;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Host pulse opening and closing
   sequence host_open;
      !host_lo ##1 host_lo;
   endsequence
   sequence host_end;
      host_lo ##1 !host_lo;
   endsequence

   AST_DEV_LOW_ONE: assert property (dev_lo |=> !dev_lo)
      else $error("device low drive longer than one clock");
   AST_DEV_HIGH_AFTER_LOW: assert property (dev_hi |-> $past(dev_lo))
      else $error("device drove high without a low before");
   AST_DEV_HIGH_ONE: assert property (dev_hi |=> !dev_oe)
      else $error("device did not float after recovery");
   AST_HOST_LOW_MIN: assert property (host_open |=> host_lo)
      else $error("host low pulse shorter than two clocks");
   AST_LINE_LOW_MAX: assert property (lo_reg <= 4'h8)
      else $error("line low for more than eight clocks");
   AST_HOST_HIGH_AFTER: assert property (host_end |-> host_hi)
      else $error("host did not drive high after its low pulse");
   AST_HOST_HIGH_ONE: assert property (host_hi |=> !host_hi)
      else $error("host high drive longer than one clock");
   AST_HOST_FIRST: assert property (dev_oe |-> seen_reg)
      else $error("device drove before any host cycle");
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb
   import sirq_pkg::*;
;
   logic        core_clk;
   logic        rst_n;
   logic        start_req;
   logic        want_quiet;
   logic        run_cont;
   logic [2:0]  start_extra;
   logic [14:0] irq_in;
   logic [14:0] d;
   logic        mode_quiet;
   logic        bus_active;
   logic        cycle_done;
   logic [15:0] irq_lvl;
   logic        q;
   logic        prev_q;
   int          err_count;
   int          check_count;
   int          cyc;
   int          run;
   int          last_run;
   int          start_run;
   int          dev_cnt;
   int          seed;
   int          i;
   int          d0;
   int          ok;

   sirq_if bus_if();
   sirq_device sirq_device_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
      .irq_in(irq_in), .mode_quiet(mode_quiet), .bus_active(bus_active), .sio(bus_if.dev));
   sirq_host sirq_host_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
      .start_req(start_req), .want_quiet(want_quiet), .run_cont(run_cont),
      .start_extra(start_extra), .irq_lvl(irq_lvl), .cycle_done(cycle_done), .sio(bus_if.host));
   sirq_asserts sirq_asserts_inst (.core_clk(core_clk), .rst_n(rst_n),
      .dev_out(bus_if.dev_out), .dev_oe(bus_if.dev_oe), .host_out(bus_if.host_out),
      .host_oe(bus_if.host_oe), .line(bus_if.line));

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Low run lengths, device drives, timeout
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
      if (bus_if.dev_oe === 1'b1 && bus_if.dev_out === 1'b0) dev_cnt++;
      if (bus_if.line === 1'b0) run++;
      else if (run > 0) begin
         if (run >= 4) start_run = run;
         last_run = run;
         run = 0;
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", name, exp, got);
      end
   endtask

   // Expected host levels: frame 1 unused and idle high
   function automatic logic [15:0] exp_lvl(input logic [14:0] v);
      return {v, 1'b1};
   endfunction

   task automatic pulse_start();
      start_req = 1'b1;
      @(negedge core_clk);
      start_req = 1'b0;
   endtask

   task automatic wait_done(output int okv);
      okv = 0;
      repeat (400) begin
         @(negedge core_clk);
         if (cycle_done === 1'b1) begin
            okv = 1;
            break;
         end
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence
   initial begin
      {rst_n, start_req, want_quiet, run_cont, prev_q} = 5'h00;
      start_extra = 3'h3;
      irq_in = 15'h7FFF;
      seed = 16018;
      repeat (2) @(negedge core_clk);
      chk("oe_rst", 16'h0000, {14'h0000, bus_if.dev_oe, bus_if.host_oe});
      rst_n = 1'b1;
      @(negedge core_clk);
      chk("mode_rst", 16'h0000, {15'h0000, mode_quiet});
      for (i = 0; i < 10; i++) begin
         q = (i == 0) ? 1'b1 : 1'($random(seed));
         d = (i == 1) ? 15'h0000 : ((i == 2) ? 15'h7FFF : 15'($random(seed)));
         start_extra = (i == 3) ? 3'h7 : 3'h3 + 3'({$random(seed)} % 5);
         want_quiet = q;
         if (prev_q) begin
            if (d == irq_in) d = d ^ 15'h0001;
            irq_in = d;
         end else begin
            d0 = dev_cnt;
            irq_in = d;
            repeat (20) @(negedge core_clk);
            chk("dev_idle", 16'(d0), 16'(dev_cnt));
            chk("mode_hold", {15'h0000, prev_q}, {15'h0000, mode_quiet});
            pulse_start();
         end
         wait_done(ok);
         chk("done", 16'h0001, 16'(ok));
         chk("irq_lvl", exp_lvl(d), irq_lvl);
         chk("stop_w", q ? 16'h0002 : 16'h0003, 16'(last_run));
         if (prev_q) chk("start_w_dev", 16'h0001, 16'(start_run >= 4 && start_run <= 8));
         else chk("start_w", 16'(start_extra) + 16'h0001, 16'(start_run));
         repeat (4) @(negedge core_clk);
         chk("mode", {15'h0000, q}, {15'h0000, mode_quiet});
         chk("active", 16'h0000, {15'h0000, bus_active});
         prev_q = q;
      end
      // Back-to-back host cycles
      want_quiet = 1'b0;
      run_cont = 1'b1;
      pulse_start();
      wait_done(ok);
      wait_done(ok);
      chk("restart", 16'h0001, 16'(ok));
      chk("irq_lvl_b2b", exp_lvl(irq_in), irq_lvl);
      run_cont = 1'b0;
      wait_done(ok);
      // Reset in mid-cycle
      pulse_start();
      repeat (30) @(negedge core_clk);
      chk("active_mid", 16'h0001, {15'h0000, bus_active});
      rst_n = 1'b0;
      @(negedge core_clk);
      chk("oe_rst2", 16'h0000, {14'h0000, bus_if.dev_oe, bus_if.host_oe});
      chk("mode_rst2", 16'h0000, {15'h0000, mode_quiet});
      @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      pulse_start();
      wait_done(ok);
      chk("done_rst2", 16'h0001, 16'(ok));
      finish_test();
   end
endmodule
